// ===== hdl/bertst_top.sv
// bit error-rate tester: tx and rx pattern generators, sync hunter, counters, axi4-lite slave
`timescale 1ns/1ps
module bertst_top
  import bertst_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic [AXI_AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [AXI_AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_TX_BIT_CLOCK,
  input wire logic I_RX_BIT_CLOCK,
  input wire logic I_RX_DATA,
  input wire logic I_EXTERNAL_UPDATE_STROBE,
  output logic O_TX_DATA,
  output logic O_RX_SYNC
);
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  wire [3:0] pin_raw = {I_EXTERNAL_UPDATE_STROBE, I_RX_DATA, I_RX_BIT_CLOCK, I_TX_BIT_CLOCK};
  wire [3:0] pin_rise = pin_s2_q & ~pin_s3_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else if (I_CE) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  logic awrdy_q;
  logic arrdy_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_prev_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [31:0] seed_q;
  logic [31:0] pm_bit_q;
  logic [31:0] pm_err_q;
  logic done_q;
  // write address and data are taken together, one access at a time
  wire aw_take = I_AWVALID && I_WVALID && !awrdy_q && !bvalid_q;
  wire ar_take = I_ARVALID && !arrdy_q && !rvalid_q;
  wire wr_en = awrdy_q;
  wire rd_en = arrdy_q;
  wire [5:0] waddr = I_AWADDR[AXI_AW-1:2];
  wire [5:0] raddr = I_ARADDR[AXI_AW-1:2];
  wire wr_ctrl = wr_en && (waddr == IDX_CTRL) && I_WSTRB[0];
  wire wr_cfg1 = wr_en && (waddr == IDX_CFG1) && I_WSTRB[0];
  wire wr_cfg2 = wr_en && (waddr == IDX_CFG2) && I_WSTRB[0];
  wire wr_seed = wr_en && (waddr == IDX_SEED);
  wire w_hit = (waddr == IDX_CTRL) || (waddr == IDX_CFG1) || (waddr == IDX_CFG2) || (waddr == IDX_SEED);
  wire r_hit = (raddr <= IDX_PMERR) && (raddr != 6'h01);
  wire [31:0] rd_mux = (raddr == IDX_CTRL) ? {24'h0, ctrl_q} :
                       (raddr == IDX_CFG1) ? {24'h0, cfg1_q} :
                       (raddr == IDX_CFG2) ? {24'h0, cfg2_q} :
                       (raddr == IDX_SEED) ? seed_q :
                       (raddr == IDX_STAT) ? {30'h0, O_RX_SYNC, done_q} :
                       (raddr == IDX_PMBIT) ? pm_bit_q :
                       (raddr == IDX_PMERR) ? pm_err_q : 32'h0000_0000;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awrdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (I_CE) begin
      awrdy_q <= aw_take;
      bvalid_q <= wr_en || (bvalid_q && !I_BREADY);
      if (wr_en) begin
        bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arrdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (I_CE) begin
      arrdy_q <= ar_take;
      rvalid_q <= rd_en || (rvalid_q && !I_RREADY);
      if (rd_en) begin
        rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_q <= rd_mux;
      end
    end
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_q <= CTRL_RST;
      ctrl_prev_q <= CTRL_RST;
      cfg1_q <= CFG_RST;
      cfg2_q <= CFG_RST;
    end else if (I_CE) begin
      ctrl_prev_q <= ctrl_q;
      if (wr_ctrl) ctrl_q <= I_WDATA[7:0];
      if (wr_cfg1) cfg1_q <= I_WDATA[7:0] & CFG1_MASK;
      if (wr_cfg2) cfg2_q <= I_WDATA[7:0] & CFG2_MASK;
    end
  end
  // seed takes each byte lane on its own strobe
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_seed
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          seed_q[gi*8 +: 8] <= SEED_RST[gi*8 +: 8];
        end else if (I_CE && wr_seed && I_WSTRB[gi]) begin
          seed_q[gi*8 +: 8] <= I_WDATA[gi*8 +: 8];
        end
      end
    end
  endgenerate
  assign O_AWREADY = awrdy_q;
  assign O_WREADY = awrdy_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arrdy_q;
  assign O_RVALID = rvalid_q;
  assign O_RRESP = rresp_q;
  assign O_RDATA = rdata_q;
  // ****************************************************
  // control edges and current generator setting
  // ****************************************************
  wire [7:0] ctrl_rise = ctrl_q & ~ctrl_prev_q;
  wire tx_load = ctrl_rise[B_TXLD];
  wire rx_load = ctrl_rise[B_RXLD];
  wire man_resync = ctrl_rise[B_MRS];
  wire [11:0] cfg_now = {cfg1_q[B_QRSS], cfg1_q[B_PTYPE], cfg1_q[LEN_MSB:0], cfg2_q[LEN_MSB:0]};
  wire tx_tick = pin_rise[PIN_TXC];
  wire rx_tick = pin_rise[PIN_RXC];
  // ****************************************************
  // transmit generator
  // ****************************************************
  logic [31:0] tx_sr_q;
  logic [11:0] tx_cfg_q;
  logic tx_data_q;
  wire tx_fb = bertst_fb(tx_sr_q, tx_cfg_q);
  wire tx_out = bertst_out(tx_sr_q, tx_cfg_q);
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_sr_q <= SEED_RST;
      tx_cfg_q <= '0;
      tx_data_q <= 1'b0;
    end else if (I_CE) begin
      if (tx_load) begin
        tx_cfg_q <= cfg_now;
        tx_sr_q <= seed_q;
      end else if (tx_tick) begin
        tx_sr_q <= {tx_sr_q[30:0], tx_fb};
        tx_data_q <= tx_out ^ ctrl_q[B_TXINV];
      end
    end
  end
  assign O_TX_DATA = tx_data_q;
  // ****************************************************
  // receive generator and sync hunter
  // ****************************************************
  // history of received bits: its feedback is the next expected bit, so hunting shifts the input in
  bertst_rx_e rx_st_q;
  bertst_rx_e rx_st_d;
  logic [31:0] rx_sr_q;
  logic [11:0] rx_cfg_q;
  logic [5:0] lock_q;
  logic [5:0] win_q;
  logic [2:0] win_err_q;
  wire rx_din = pin_s2_q[PIN_RXD] ^ ctrl_q[B_RXINV];
  wire rx_exp = bertst_fb(rx_sr_q, rx_cfg_q);
  wire rx_mism = (rx_din != rx_exp) && !(rx_cfg_q[CF_QRSS] && rx_din && !rx_exp); // forced qrss ones not counted
  wire in_sync = (rx_st_q == RX_SYNC);
  wire force_hunt = rx_load || man_resync;
  wire lock_hit = !rx_mism && (lock_q == LOCK_LAST);
  wire auto_hit = rx_mism && (win_err_q == ERR_LAST) && !ctrl_q[B_ARD];
  wire win_wrap = (win_q == WIN_LAST);
  always_comb begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      RX_HUNT: begin
        if (!force_hunt && rx_tick && lock_hit) rx_st_d = RX_SYNC;
      end
      RX_SYNC: begin
        if (force_hunt || (rx_tick && auto_hit)) rx_st_d = RX_HUNT;
      end
      default: rx_st_d = RX_HUNT;
    endcase
  end
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_st_q <= RX_HUNT;
      rx_sr_q <= SEED_RST;
      rx_cfg_q <= '0;
      lock_q <= '0;
      win_q <= '0;
      win_err_q <= '0;
    end else if (I_CE) begin
      rx_st_q <= rx_st_d;
      if (rx_load) begin
        rx_cfg_q <= cfg_now;
        rx_sr_q <= seed_q;
      end else if (rx_tick) begin
        rx_sr_q <= {rx_sr_q[30:0], in_sync ? rx_exp : rx_din};
      end
      if (force_hunt || (rx_tick && !in_sync)) begin
        win_q <= '0;
        win_err_q <= '0;
      end else if (rx_tick) begin
        win_q <= win_q + 6'h01;
        // saturate: with auto resync disabled the count must hold at five and not wrap
        win_err_q <= win_wrap ? 3'h0 : (win_err_q + {2'h0, rx_mism && (win_err_q != ERR_LAST)});
      end
      if (force_hunt || in_sync || (rx_tick && rx_mism)) begin
        lock_q <= '0;
      end else if (rx_tick) begin
        lock_q <= lock_q + 6'h01;
      end
    end
  end
  assign O_RX_SYNC = in_sync;
  // ****************************************************
  // performance counters and update
  // ****************************************************
  logic [31:0] bit_cnt_q;
  logic [31:0] err_cnt_q;
  wire loc_rise = ctrl_rise[B_LUPD];
  wire ext_rise = pin_rise[PIN_EXT];
  wire upd = ctrl_q[B_UMODE] ? ext_rise : loc_rise;
  wire trig_lvl = ctrl_q[B_UMODE] ? pin_s2_q[PIN_EXT] : ctrl_q[B_LUPD];
  wire err_inc = rx_tick && in_sync && rx_mism;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_cnt_q <= '0;
      err_cnt_q <= '0;
      pm_bit_q <= '0;
      pm_err_q <= '0;
      done_q <= 1'b0;
    end else if (I_CE) begin
      // a bit that arrives with the update starts the new count
      bit_cnt_q <= (upd ? 32'h0 : bit_cnt_q) + {31'h0, rx_tick};
      err_cnt_q <= (upd ? 32'h0 : err_cnt_q) + {31'h0, err_inc};
      if (upd) begin
        pm_bit_q <= bit_cnt_q;
        pm_err_q <= err_cnt_q;
      end
      done_q <= upd || (done_q && trig_lvl);
    end
  end
  // ****************************************************
  // checks
  // ****************************************************
  a_local_update: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && !ctrl_q[B_UMODE] && loc_rise) |=> (done_q && pm_err_q == $past(err_cnt_q)))
    else $error("local update did not latch counts");
  a_local_ignored: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && ctrl_q[B_UMODE] && loc_rise && !ext_rise) |=> $stable(pm_bit_q))
    else $error("local bit updated in external mode");
  a_ext_update: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && ctrl_q[B_UMODE] && ext_rise) |=> (done_q && pm_bit_q == $past(bit_cnt_q)))
    else $error("external strobe did not update");
  a_rx_load_hunt: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && rx_load) |=> (rx_st_q == RX_HUNT && rx_cfg_q == $past(cfg_now)))
    else $error("rx load did not force hunt");
  a_resync_hunt: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && man_resync) |=> !O_RX_SYNC)
    else $error("manual resync did not leave sync");
  a_auto_resync: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && in_sync && rx_tick && rx_mism && win_err_q == ERR_LAST && !ctrl_q[B_ARD]) |=> !O_RX_SYNC)
    else $error("sixth error did not resync");
  a_no_auto_exit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && in_sync && ctrl_q[B_ARD] && !force_hunt) |=> O_RX_SYNC)
    else $error("sync lost with auto resync disabled");
  a_tx_load: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && tx_load) |=> (tx_sr_q == $past(seed_q) && tx_cfg_q == $past(cfg_now)))
    else $error("tx load did not take settings");
  a_tx_invert: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && tx_tick && !tx_load) |=> (O_TX_DATA == ($past(tx_out) ^ $past(ctrl_q[B_TXINV]))))
    else $error("tx bit or inversion wrong");
  a_qrss_force: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && tx_tick && !tx_load && tx_cfg_q[CF_QRSS] && tx_sr_q[QRSS_ZMSB:QRSS_ZLSB] == '0)
    |=> (O_TX_DATA == !$past(ctrl_q[B_TXINV])))
    else $error("qrss zero run not broken");
endmodule : bertst_top

// ===== hdl/bertst_pkg.sv
// shared constants, types and generator functions for the bit error-rate tester
package bertst_pkg;

  // ****************************************************
  // register map (word index, byte address is index * 4)
  // ****************************************************
  localparam int unsigned AXI_AW = 8;
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_CFG1 = 6'h02;
  localparam logic [5:0] IDX_CFG2 = 6'h03;
  localparam logic [5:0] IDX_SEED = 6'h04;
  localparam logic [5:0] IDX_STAT = 6'h05;
  localparam logic [5:0] IDX_PMBIT = 6'h06;
  localparam logic [5:0] IDX_PMERR = 6'h07;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [31:0] SEED_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int B_UMODE = 7;
  localparam int B_LUPD = 6;
  localparam int B_RXLD = 5;
  localparam int B_RXINV = 4;
  localparam int B_MRS = 3;
  localparam int B_ARD = 2;
  localparam int B_TXLD = 1;
  localparam int B_TXINV = 0;
  localparam int B_QRSS = 6;
  localparam int B_PTYPE = 5;
  localparam int LEN_MSB = 4;
  localparam logic [7:0] CFG1_MASK = 8'h7F;
  localparam logic [7:0] CFG2_MASK = 8'h1F;
  localparam int B_DONE = 0;
  localparam int B_SYNC = 1;
  // packed generator setting {qrss, type, length, tap}
  localparam int CF_QRSS = 11;
  localparam int CF_PTYPE = 10;
  localparam int CF_LEN_MSB = 9;
  localparam int CF_LEN_LSB = 5;
  localparam int CF_TAP_MSB = 4;
  // pin synchroniser lanes
  localparam int PIN_TXC = 0;
  localparam int PIN_RXC = 1;
  localparam int PIN_RXD = 2;
  localparam int PIN_EXT = 3;

  // ****************************************************
  // pattern constants
  // ****************************************************
  localparam logic [4:0] QRSS_LEN_IDX = 5'h13;
  localparam logic [4:0] QRSS_TAP_IDX = 5'h10;
  localparam int QRSS_ZMSB = 19;
  localparam int QRSS_ZLSB = 6;
  localparam logic [2:0] ERR_LAST = 3'h5;
  localparam logic [5:0] WIN_LAST = 6'h3F;
  localparam logic [5:0] LOCK_LAST = 6'h27;

  typedef enum logic {RX_HUNT, RX_SYNC} bertst_rx_e;

  // feedback bit shifted into stage 1
  function automatic logic bertst_fb(input logic [31:0] sr, input logic [11:0] cfg);
    logic [4:0] n;
    logic [4:0] y;
    n = cfg[CF_QRSS] ? QRSS_LEN_IDX : cfg[CF_LEN_MSB:CF_LEN_LSB];
    y = cfg[CF_QRSS] ? QRSS_TAP_IDX : cfg[CF_TAP_MSB:0];
    return (cfg[CF_PTYPE] && !cfg[CF_QRSS]) ? sr[n] : (sr[n] ^ sr[y]);
  endfunction : bertst_fb

  // bit leaving stage n, forced high ahead of a long zero run in qrss mode
  function automatic logic bertst_out(input logic [31:0] sr, input logic [11:0] cfg);
    if (cfg[CF_QRSS]) begin
      return (sr[QRSS_ZMSB:QRSS_ZLSB] == '0) ? 1'b1 : sr[QRSS_LEN_IDX];
    end
    return sr[cfg[CF_LEN_MSB:CF_LEN_LSB]];
  endfunction : bertst_out

endpackage : bertst_pkg

// ===== verif/bertst_line_model.sv
// line channel model: shared free-running bit clock and tx-to-rx loopback
`timescale 1ns/1ps
module bertst_line_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_data,
  input wire logic i_flip,
  output logic o_bit_clock,
  output logic o_rx_data
);
  logic [2:0] ph_q;

  // ****************************************************
  // eight system clocks per bit, four high and four low
  // ****************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q <= 3'h0;
      o_rx_data <= 1'b0;
    end else begin
      ph_q <= ph_q + 3'h1;
      // loop back at the clock fall: after the tx update, clear of the rx hold window
      if (ph_q == 3'h7) begin
        o_rx_data <= i_tx_data ^ i_flip;
      end
    end
  end

  // low in reset, so the first rise the block sees is a real bit
  assign o_bit_clock = ph_q[2];
endmodule : bertst_line_model

// ===== verif/test_bit_error_rate_tester.sv
// self-checking bench for the bit error-rate tester with a looped-back line
`timescale 1ns/1ps
module test_bit_error_rate_tester
  import bertst_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic stb = 1'b0, flip = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic bclk, rxd, awr, wrdy, bvalid, arr, rvalid, txd, sync;
  logic [31:0] rdat, rv;
  logic [1:0] br, rr, rsp;
  logic [63:0] bits = '0;
  int mismatches = 0;
  int n_compared = 0;

  bertst_top uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(br),
    .O_BVALID(bvalid), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rvalid), .I_RREADY(rrdy), .I_TX_BIT_CLOCK(bclk),
    .I_RX_BIT_CLOCK(bclk), .I_RX_DATA(rxd), .I_EXTERNAL_UPDATE_STROBE(stb), .O_TX_DATA(txd),
    .O_RX_SYNC(sync));
  bertst_line_model line (.i_clk(clk), .i_rst_n(rst_n), .i_tx_data(txd), .i_flip(flip),
    .o_bit_clock(bclk), .o_rx_data(rxd));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s: got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    k = 0;
    @(posedge clk);
    while (bvalid !== 1'b1) begin
      if (awr === 1'b1) awv <= 1'b0;
      if (wrdy === 1'b1) wv <= 1'b0;
      k++;
      @(posedge clk);
    end
    brdy <= 1'b0;
    rsp = br;
    chk(k, 2, "write answer latency");
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    int k;
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'b1;
    rrdy <= 1'b1;
    k = 0;
    @(posedge clk);
    while (rvalid !== 1'b1) begin
      if (arr === 1'b1) arv <= 1'b0;
      k++;
      @(posedge clk);
    end
    rrdy <= 1'b0;
    rv = rdat;
    rsp = rr;
    chk(k, 2, "read answer latency");
  endtask : rd

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    rd(idx);
    chk(rv, exp, "read data");
    chk(rsp, er, "read response");
  endtask : rdc

  // settings stay put for forty clocks, five bit clocks, after a load
  task automatic load(input logic [7:0] c1, input logic [7:0] c2, input logic [31:0] s, input logic [7:0] c);
    wr(IDX_CFG1, {24'h0, c1});
    wr(IDX_CFG2, {24'h0, c2});
    wr(IDX_SEED, s);
    wr(IDX_CTRL, {24'h0, c});
    cyc(40);
    wr(IDX_CTRL, {24'h0, c & 8'hDD});
  endtask : load

  task automatic grab(input int n);
    repeat (n) begin
      @(negedge bclk);
      #1 bits = {bits[62:0], txd};
    end
  endtask : grab

  task automatic wsync(input logic exp, input int lim, input string what);
    int k;
    for (k = 0; k < lim && sync !== exp; k++) @(posedge clk);
    chk(sync, exp, what);
  endtask : wsync

  task automatic wdone(input logic exp);
    for (int k = 0; k < 20; k++) begin
      rd(IDX_STAT);
      if (rv[B_DONE] === exp) break;
    end
    chk(rv[B_DONE], exp, "update done");
  endtask : wdone

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_regs();
    rdc(IDX_CTRL, 32'h0, RESP_OKAY);
    rdc(IDX_CFG1, 32'h0, RESP_OKAY);
    rdc(IDX_CFG2, 32'h0, RESP_OKAY);
    rdc(IDX_SEED, 32'h0, RESP_OKAY);
    rdc(IDX_STAT, 32'h0, RESP_OKAY);
    rdc(6'h01, 32'h0, RESP_SLVERR);
    wr(6'h01, 32'hFFFF_FFFF);
    chk(rsp, RESP_SLVERR, "unmapped write");
    wr(IDX_CFG1, 32'hFFFF_FFFF);
    rdc(IDX_CFG1, {24'h0, CFG1_MASK}, RESP_OKAY);
    wr(IDX_CFG2, 32'hFFFF_FFFF);
    rdc(IDX_CFG2, {24'h0, CFG2_MASK}, RESP_OKAY);
    wr(IDX_SEED, 32'hA5C3_0F96);
    rdc(IDX_SEED, 32'hA5C3_0F96, RESP_OKAY);
    $display("registers test ended");
  endtask : t_regs

  // eight-bit repetitive word, plain and inverted; tap field must not matter
  task automatic t_rep();
    logic [7:0] w;
    int hit;
    for (int v = 0; v < 2; v++) begin
      load(8'h27, 8'h03, 32'h0000_00B1, 8'h02 | v[7:0]);
      grab(16);
      chk(bits[15:8], bits[7:0], "repeat period");
      w = 8'hB1 ^ {8{v[0]}};
      hit = 0;
      for (int r = 0; r < 8; r++) begin
        if (bits[7:0] === ((w << r) | (w >> (8 - r)))) hit = 1;
      end
      chk(hit, 1, "pattern word");
    end
    $display("repetitive test ended");
  endtask : t_rep

  task automatic t_prbs();
    int z;
    int zmax;
    load(8'h06, 8'h05, 32'h0000_0055, 8'h02);
    grab(40);
    chk(bits[39:0] != '0, 1, "prbs running");
    for (int t = 0; t < 33; t++) chk(bits[t], bits[t + 7] ^ bits[t + 6], "prbs step");
    load(8'h40, 8'h00, 32'h0000_0001, 8'h02);
    z = 0;
    zmax = 0;
    repeat (300) begin
      grab(1);
      z = bits[0] ? 0 : z + 1;
      if (z > zmax) zmax = z;
    end
    chk(zmax <= 14, 1, "qrss zero run");
    $display("prbs test ended");
  endtask : t_prbs

  task automatic t_sync();
    load(8'h06, 8'h05, 32'h0000_007F, 8'h22);
    wsync(1'b1, 1500, "first lock");
    wr(IDX_CTRL, 32'h08);
    cyc(3);
    chk(sync, 1'b0, "manual resync");
    wr(IDX_CTRL, 32'h00);
    wsync(1'b1, 1500, "relock");
    // five bad bits stay under the threshold
    @(negedge bclk);
    flip <= 1'b1;
    cyc(40);
    flip <= 1'b0;
    cyc(16);
    chk(sync, 1'b1, "five errors kept");
    wr(IDX_CTRL, 32'h04);
    flip <= 1'b1;
    cyc(800);
    chk(sync, 1'b1, "auto resync off");
    wr(IDX_CTRL, 32'h00);
    wsync(1'b0, 700, "auto resync");
    flip <= 1'b0;
    wsync(1'b1, 1500, "relock");
    wr(IDX_CTRL, 32'h10);
    flip <= 1'b1;
    cyc(800);
    chk(sync, 1'b1, "inverted stream");
    flip <= 1'b0;
    wsync(1'b0, 700, "invert mismatch");
    wr(IDX_CTRL, 32'h00);
    wsync(1'b1, 1500, "relock");
    wr(IDX_CTRL, 32'h20);
    cyc(3);
    chk(sync, 1'b0, "rx load");
    wr(IDX_CTRL, 32'h00);
    wsync(1'b1, 1500, "relock");
    $display("sync test ended");
  endtask : t_sync

  task automatic t_upd();
    wr(IDX_CTRL, 32'h40);
    wdone(1'b1);
    wr(IDX_CTRL, 32'h00);
    wdone(1'b0);
    stb <= 1'b1;
    cyc(20);
    rd(IDX_STAT);
    chk(rv[B_DONE], 1'b0, "strobe ignored");
    stb <= 1'b0;
    wr(IDX_CTRL, 32'h80);
    wr(IDX_CTRL, 32'hC0);
    cyc(20);
    rd(IDX_STAT);
    chk(rv[B_DONE], 1'b0, "local ignored");
    wr(IDX_CTRL, 32'h84);
    flip <= 1'b1;
    cyc(20);
    // two strobe rises exactly one hundred bits apart
    stb <= 1'b1;
    cyc(20);
    stb <= 1'b0;
    cyc(780);
    stb <= 1'b1;
    cyc(20);
    stb <= 1'b0;
    flip <= 1'b0;
    rdc(IDX_PMBIT, 32'h64, RESP_OKAY);
    rdc(IDX_PMERR, 32'h64, RESP_OKAY);
    wr(IDX_CTRL, 32'h04);
    $display("update test ended");
  endtask : t_upd

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    cyc(40000);
    mismatches++;
    test_done();
  end

  initial begin
    cyc(8);
    rst_n <= 1'b1;
    t_regs();
    t_rep();
    t_prbs();
    t_sync();
    t_upd();
    test_done();
  end
endmodule : test_bit_error_rate_tester
